// ===== scan_ctrl_pkg.sv
// Constants for the channel and interrupt control of the acquisition card.
// Assumes a single 100 MHz clock and a byte-wide host register port.
package scan_ctrl_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CODE_W = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CHAN_CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] ADC_CLEAR_OFS = 4'h1;
  localparam logic [ADDR_W-1:0] CONFIG_OFS = 4'h5;
  localparam logic [ADDR_W-1:0] TIMER_CLEAR_OFS = 4'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SCAN_OFF_POS = 7;
  localparam int CNT_EN_POS = 6;
  localparam int EXT_EN_POS = 5;
  localparam int QUEUE_EN_POS = 4;
  localparam int HALF_SEL_POS = 5;
  localparam int CLK_SRC_POS = 3;
  localparam int PAIRED_POS = 2;
  localparam int RANGE_HI_POS = 1;
  localparam int RANGE_LO_POS = 0;

  localparam int ST_ONE_POS = 7;
  localparam int ST_HALF_N_POS = 6;
  localparam int ST_BUSY_POS = 4;
  localparam int ST_EXT_N_POS = 3;
  localparam int ST_CNT_POS = 2;
  localparam int ST_ERR_POS = 1;
  localparam int ST_AVAIL_POS = 0;

  // ----------------------------------------------------------------
  // Reset values and decode constants
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CMD_RESET = 8'h00;
  localparam logic [CODE_W-1:0] CODE_ZERO = 4'h0;
  localparam logic [CODE_W-1:0] PAIR_OFFSET = 4'h8;
endpackage

// ===== mux_link_if.sv
// Carrier between the register logic and the channel sequencer.
// Assumes both ends share sys_clk.
interface mux_link_if;
  import scan_ctrl_pkg::*;
  logic [CODE_W-1:0] code;
  logic scan_off;
  logic paired;
  logic load;
  logic step;
  logic [CODE_W-1:0] pos;
  logic [CODE_W-1:0] neg;
  logic neg_en;
  logic ground;

  modport ctrl
  (
    output code, scan_off, paired, load, step,
    input pos, neg, neg_en, ground
  );
  modport seq
  (
    input code, scan_off, paired, load, step,
    output pos, neg, neg_en, ground
  );
endinterface

// ===== channel_sequencer.sv
// Scan counter and analog multiplexer decode.
// Assumes load and step arrive as one-cycle pulses on sys_clk.
module channel_sequencer
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Link to register logic
  mux_link_if.seq lnk
);
  import scan_ctrl_pkg::*;

  typedef struct packed
  {
    logic [CODE_W-1:0] count;
    logic [CODE_W-1:0] pos;
    logic [CODE_W-1:0] neg;
    logic neg_en;
    logic ground;
  } seq_state_t;

  seq_state_t st;
  seq_state_t next_st;
  logic [CODE_W-1:0] start;
  logic [CODE_W-1:0] active;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // Paired scanning stays within the first eight channels
    start = lnk.paired ? {1'b0, lnk.code[CODE_W-2:0]} : lnk.code;
    if (lnk.load)
    begin
      next_st.count = start;
    end
    else if (lnk.step && !lnk.scan_off)
    begin
      if (st.count == CODE_ZERO)
      begin
        next_st.count = start;
      end
      else
      begin
        next_st.count = st.count - 4'h1;
      end
    end
    active = lnk.scan_off ? lnk.code : st.count;
    if (lnk.paired && active[CODE_W-1])
    begin
      next_st.ground = 1'b1;
      next_st.neg_en = 1'b0;
      next_st.pos = CODE_ZERO;
      next_st.neg = CODE_ZERO;
    end
    else if (lnk.paired)
    begin
      next_st.ground = 1'b0;
      next_st.neg_en = 1'b1;
      next_st.pos = active;
      next_st.neg = active + PAIR_OFFSET;
    end
    else
    begin
      next_st.ground = 1'b0;
      next_st.neg_en = 1'b0;
      next_st.pos = active;
      next_st.neg = CODE_ZERO;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign lnk.pos = st.pos;
  assign lnk.neg = st.neg;
  assign lnk.neg_en = st.neg_en;
  assign lnk.ground = st.ground;

  a_scan_down: assert property (@(posedge sys_clk) disable iff (srst)
    (lnk.step && !lnk.scan_off && !lnk.load && st.count != CODE_ZERO)
    |=> st.count == $past(st.count) - 4'h1)
    else $error("scan counter did not step down");

  a_scan_wrap: assert property (@(posedge sys_clk) disable iff (srst)
    (lnk.step && !lnk.scan_off && !lnk.load && st.count == CODE_ZERO
     && !lnk.paired)
    |=> st.count == $past(lnk.code))
    else $error("scan counter did not wrap to start");

  a_single_hold: assert property (@(posedge sys_clk) disable iff (srst)
    (lnk.scan_off && !lnk.paired) |=> lnk.pos == $past(lnk.code))
    else $error("single channel not selected");

  a_pair_ground: assert property (@(posedge sys_clk) disable iff (srst)
    (lnk.scan_off && lnk.paired && lnk.code[CODE_W-1])
    |=> lnk.ground && !lnk.neg_en)
    else $error("grounded input not selected");

  a_pair_neg: assert property (@(posedge sys_clk) disable iff (srst)
    (lnk.scan_off && lnk.paired && !lnk.code[CODE_W-1])
    |=> lnk.neg_en && lnk.neg == $past(lnk.code) + PAIR_OFFSET)
    else $error("negative pair channel wrong");
endmodule

// ===== scan_control.sv
// Command registers, status read-back and interrupt request of the
// channel scan control. Assumes host bus strobes are one-cycle pulses
// synchronous to sys_clk; other registers on the card decode elsewhere.
module scan_control
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Host register port
  input wire logic [scan_ctrl_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [scan_ctrl_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [scan_ctrl_pkg::DATA_W-1:0] bus_rdata,
  // Converter and sample queue status
  input wire logic conv_active,
  input wire logic conv_done,
  input wire logic data_error,
  input wire logic queue_not_empty,
  input wire logic queue_half_full,
  // Interrupt sources
  input wire logic counter_out,
  input wire logic external_irq_request_n,
  // Analog front end
  output logic [scan_ctrl_pkg::CODE_W-1:0] mux_pos_sel,
  output logic [scan_ctrl_pkg::CODE_W-1:0] mux_neg_sel,
  output logic mux_neg_enable,
  output logic ground_input_select,
  output logic [1:0] input_range,
  output logic clk1_internal,
  output logic adc_clear,
  // Host interrupt
  output logic irq
);
  import scan_ctrl_pkg::*;

  typedef struct packed
  {
    logic scan_off_bit;
    logic counter_irq_enable;
    logic external_irq_enable;
    logic sample_queue_irq_enable;
    logic [CODE_W-1:0] mux_channel_code;
    logic half_level_irq_select;
    logic clk1_internal;
    logic paired_input_select;
    logic [1:0] input_range;
    logic load;
    logic counter_prev;
    logic counter_flag;
    logic adc_clear;
    logic irq;
    logic [DATA_W-1:0] rdata;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;
  logic wr_chan;
  logic wr_config;
  logic cnt_rise;
  logic queue_req;

  mux_link_if lnk ();

  channel_sequencer u_seq
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .lnk(lnk.seq)
  );

  // ----------------------------------------------------------------
  // Register writes, flags and read-back
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    wr_chan = bus_wr && bus_addr == CHAN_CTRL_OFS;
    wr_config = bus_wr && bus_addr == CONFIG_OFS;
    if (wr_chan)
    begin
      next_st.scan_off_bit = bus_wdata[SCAN_OFF_POS];
      next_st.counter_irq_enable = bus_wdata[CNT_EN_POS];
      next_st.external_irq_enable = bus_wdata[EXT_EN_POS];
      next_st.sample_queue_irq_enable = bus_wdata[QUEUE_EN_POS];
      next_st.mux_channel_code = bus_wdata[CODE_W-1:0];
    end
    // Reserved config bits are simply not stored
    if (wr_config)
    begin
      next_st.half_level_irq_select = bus_wdata[HALF_SEL_POS];
      next_st.clk1_internal = bus_wdata[CLK_SRC_POS];
      next_st.paired_input_select = bus_wdata[PAIRED_POS];
      next_st.input_range = bus_wdata[RANGE_HI_POS:RANGE_LO_POS];
    end
    // Set-low inverted bit means scanning; a set write loads the counter
    next_st.load = wr_chan && bus_wdata[SCAN_OFF_POS];
    next_st.adc_clear = bus_write_strobe(bus_wr, bus_addr, ADC_CLEAR_OFS);
    cnt_rise = counter_out && !st.counter_prev;
    next_st.counter_prev = counter_out;
    // Edge arriving with a clear write still latches
    if (st.counter_irq_enable && cnt_rise)
    begin
      next_st.counter_flag = 1'b1;
    end
    else if (bus_write_strobe(bus_wr, bus_addr, TIMER_CLEAR_OFS))
    begin
      next_st.counter_flag = 1'b0;
    end
    queue_req = st.half_level_irq_select ? queue_half_full
                                         : queue_not_empty;
    next_st.irq = st.counter_flag
      || (st.external_irq_enable && !external_irq_request_n)
      || (st.sample_queue_irq_enable && queue_req);
    next_st.rdata = '0;
    if (bus_rd && bus_addr == STATUS_OFS)
    begin
      next_st.rdata[ST_ONE_POS] = 1'b1;
      next_st.rdata[ST_HALF_N_POS] = !queue_half_full;
      next_st.rdata[ST_BUSY_POS] = conv_active;
      next_st.rdata[ST_EXT_N_POS] = external_irq_request_n;
      next_st.rdata[ST_CNT_POS] = st.counter_flag;
      next_st.rdata[ST_ERR_POS] = data_error;
      next_st.rdata[ST_AVAIL_POS] = queue_not_empty;
    end
  end

  function automatic logic bus_write_strobe
  (
    input logic wr,
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] ofs
  );
    bus_write_strobe = wr && addr == ofs;
  endfunction

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer link and outputs
  // ----------------------------------------------------------------
  assign lnk.code = st.mux_channel_code;
  assign lnk.scan_off = st.scan_off_bit;
  assign lnk.paired = st.paired_input_select;
  assign lnk.load = st.load;
  assign lnk.step = conv_done;

  assign mux_pos_sel = lnk.pos;
  assign mux_neg_sel = lnk.neg;
  assign mux_neg_enable = lnk.neg_en;
  assign ground_input_select = lnk.ground;
  assign input_range = st.input_range;
  assign clk1_internal = st.clk1_internal;
  assign adc_clear = st.adc_clear;
  assign irq = st.irq;
  assign bus_rdata = st.rdata;

  a_reset_clear: assert property (@(posedge sys_clk)
    srst |=> st.mux_channel_code == CMD_RESET[CODE_W-1:0] && !irq
      && !st.scan_off_bit && !st.paired_input_select)
    else $error("command bits not cleared by reset");

  a_strobe_pulse: assert property (@(posedge sys_clk) disable iff (srst)
    (bus_wr && bus_addr == ADC_CLEAR_OFS) |=> adc_clear ##1 (!adc_clear
      || $past(bus_wr && bus_addr == ADC_CLEAR_OFS)))
    else $error("clear strobe not a single pulse");

  a_cnt_latch: assert property (@(posedge sys_clk) disable iff (srst)
    (st.counter_irq_enable && counter_out && !st.counter_prev)
    |=> st.counter_flag ##1 irq)
    else $error("counter interrupt not raised");

  a_cnt_clear: assert property (@(posedge sys_clk) disable iff (srst)
    (bus_wr && bus_addr == TIMER_CLEAR_OFS
     && !(st.counter_irq_enable && counter_out && !st.counter_prev))
    |=> !st.counter_flag)
    else $error("counter interrupt not cleared");

  a_ext_irq: assert property (@(posedge sys_clk) disable iff (srst)
    (st.external_irq_enable && !external_irq_request_n) |=> irq)
    else $error("external interrupt not raised");

  a_queue_half: assert property (@(posedge sys_clk) disable iff (srst)
    (st.sample_queue_irq_enable && st.half_level_irq_select
     && queue_half_full) |=> irq)
    else $error("half level interrupt missing");

  a_status_read: assert property (@(posedge sys_clk) disable iff (srst)
    (bus_rd && bus_addr == STATUS_OFS) |=> bus_rdata[ST_ONE_POS]
      && bus_rdata[ST_CNT_POS] == $past(st.counter_flag)
      && bus_rdata[ST_HALF_N_POS] == !$past(queue_half_full))
    else $error("status read-back wrong");

  a_chan_write: assert property (@(posedge sys_clk) disable iff (srst)
    (bus_wr && bus_addr == CHAN_CTRL_OFS)
    |=> st.scan_off_bit == $past(bus_wdata[SCAN_OFF_POS])
      && st.mux_channel_code == $past(bus_wdata[CODE_W-1:0]))
    else $error("control byte not captured");
endmodule

// ===== acq_source_model.sv
// Model of the converter, sample queue, counter and external source.
// Assumes the bench calls its tasks from a process clocked by sys_clk.
module acq_source_model
(
  // Clock
  input wire logic sys_clk,
  // Source levels and pulses
  output logic conv_active,
  output logic conv_done,
  output logic data_error,
  output logic queue_not_empty,
  output logic queue_half_full,
  output logic counter_out,
  output logic external_irq_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {conv_active, conv_done, data_error} = 3'h0;
    {queue_not_empty, queue_half_full, counter_out} = 3'h0;
    external_irq_request_n = 1'b1;
  end
  // One conversion: busy and done share a single cycle
  task automatic convert();
    @(posedge sys_clk);
    conv_active <= 1'b1;
    conv_done <= 1'b1;
    @(posedge sys_clk);
    conv_active <= 1'b0;
    conv_done <= 1'b0;
  endtask
  // Busy, error, queue, half, counter, request; request is active low and
  // every level except busy, which convert also drives, holds until the bench calls set_levels again
  task automatic set_levels(input logic [5:0] v);
    @(posedge sys_clk);
    {conv_active, data_error, queue_not_empty, queue_half_full,
      counter_out, external_irq_request_n} <= v;
  endtask
endmodule

// ===== test_scan_control.sv
// Self-checking bench for the channel scan control.
// Assumes the package and the source model are compiled first.
module test_scan_control;
  timeunit 1ns;
  timeprecision 1ps;
  import scan_ctrl_pkg::*;
  typedef struct {string nm; logic [22:0] m; logic [22:0] v;} note_t;
  localparam logic [22:0] MUXM = 23'h001FF8;
  localparam logic [22:0] MSE = 23'h001E18;
  localparam logic [22:0] IRQM = 23'h000004;
  // Status bit 5 carries nothing, so it stays masked
  localparam logic [22:0] STM = 23'h1BE000;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] bus_addr = 4'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic look = 1'b0;
  logic [31:0] seed = 32'h7886;
  logic [31:0] r;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  int e;
  note_t n;
  note_t notes[$];
  logic [7:0] bus_rdata;
  logic [3:0] mux_pos_sel;
  logic [3:0] mux_neg_sel;
  logic [1:0] input_range;
  logic conv_active, conv_done, data_error, queue_not_empty;
  logic queue_half_full, counter_out, external_irq_request_n;
  logic mux_neg_enable, ground_input_select, clk1_internal;
  logic adc_clear, irq;
  logic [22:0] obs;
  assign obs = {clk1_internal, adc_clear, bus_rdata, mux_pos_sel,
    mux_neg_sel, mux_neg_enable, ground_input_select, irq, input_range};
  scan_control DUT
  (
    .sys_clk, .srst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .conv_active, .conv_done, .data_error,
    .queue_not_empty, .queue_half_full, .counter_out,
    .external_irq_request_n, .mux_pos_sel, .mux_neg_sel,
    .mux_neg_enable, .ground_input_select, .input_range,
    .clk1_internal, .adc_clear, .irq
  );
  acq_source_model src
  (
    .sys_clk, .conv_active, .conv_done, .data_error, .queue_not_empty,
    .queue_half_full, .counter_out, .external_irq_request_n
  );
  always #5 sys_clk = ~sys_clk;
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [22:0] mx(logic [3:0] p, logic [3:0] q,
    logic ne, logic g);
    return {10'h000, p, q, ne, g, 3'h0};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Peek looks at the strobe cycle that follows the write edge
  task automatic wr(logic [3:0] a, logic [7:0] d, logic p);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    look <= p;
    if (p)
      notes.push_back('{"adc_clear", 23'h200000, {1'b0, a == 4'h1, 21'h0}});
    @(posedge sys_clk);
    look <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] x);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    look <= 1'b1;
    notes.push_back('{"bus_rdata", STM, {2'h0, x, 13'h0}});
    @(posedge sys_clk);
    look <= 1'b0;
  endtask
  task automatic chk(string s, logic [22:0] m, logic [22:0] v);
    repeat (3) @(posedge sys_clk);
    look <= 1'b1;
    notes.push_back('{s, m, v});
    @(posedge sys_clk);
    look <= 1'b0;
  endtask
  // --------------------------------------------------------------
  // Watcher and hang guard
  // --------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      err_total++;
      give_verdict();
    end
    if (look && notes.size() > 0)
    begin
      n = notes.pop_front();
      checked++;
      if ((obs & n.m) !== n.v)
      begin
        err_total++;
        $display("Error %s expected %h seen %h", n.nm, n.v, obs & n.m);
      end
    end
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    chk("reset", 23'h7FFFFF, 23'h0);
    rd(4'h0, 8'hC8);
    for (int c = 0; c < 16; c++)
    begin
      wr(4'h0, 8'h80 | 8'(c), 1'b0);
      src.convert();
      chk("single", MSE, mx(4'(c), 4'h0, 1'b0, 1'b0));
    end
    r = rnd();
    wr(4'h5, 8'h04 | (r[7:0] & 8'hDB), 1'b0);
    chk("config", 23'h400003, {r[3], 20'h0, r[1:0]});
    for (int c = 0; c < 16; c++)
    begin
      wr(4'h0, 8'h80 | 8'(c), 1'b0);
      if (c < 8)
        chk("pair", MUXM, mx(4'(c), 4'(c + 8), 1'b1, 1'b0));
      else
        chk("ground", MSE, mx(4'h0, 4'h0, 1'b0, 1'b1));
    end
    $display("mux tests finished");
    wr(4'h5, 8'h00, 1'b0);
    wr(4'h0, 8'h83, 1'b0);
    wr(4'h0, 8'h03, 1'b0);
    e = 3;
    chk("scan", MSE, mx(4'(e), 4'h0, 1'b0, 1'b0));
    for (int k = 0; k < 6; k++)
    begin
      src.convert();
      e = (e == 0) ? 3 : e - 1;
      chk("scan", MSE, mx(4'(e), 4'h0, 1'b0, 1'b0));
    end
    $display("scan test finished");
    src.set_levels(6'b000011);
    chk("cnt_off", IRQM, 23'h0);
    src.set_levels(6'b000001);
    wr(4'h0, 8'hC0, 1'b0);
    // Random busy and error levels reach the status read-back
    src.set_levels({r[31:30], 4'b0011});
    chk("cnt_irq", IRQM, IRQM);
    rd(4'h0, 8'hCC | {3'h0, r[31], 2'h0, r[30], 1'b0});
    r = rnd();
    wr(4'h6, r[7:0], 1'b0);
    chk("cnt_clr", IRQM, 23'h0);
    wr(4'h1, r[15:8], 1'b1);
    wr(4'h0, 8'hA0, 1'b0);
    src.set_levels(6'b000000);
    chk("ext_irq", IRQM, IRQM);
    rd(4'h0, 8'hC0);
    src.set_levels(6'b000001);
    chk("ext_off", IRQM, 23'h0);
    wr(4'h0, 8'h90, 1'b0);
    src.set_levels(6'b001001);
    chk("queue_one", IRQM, IRQM);
    wr(4'h5, 8'h20, 1'b0);
    chk("queue_half", IRQM, 23'h0);
    src.set_levels(6'b011101);
    chk("queue_full", IRQM, IRQM);
    rd(4'h0, 8'h8B);
    wr(4'hC, r[23:16], 1'b0);
    rd(4'h5, 8'h00);
    chk("unmapped", IRQM, IRQM);
    $display("interrupt tests finished");
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    chk("mid_reset", 23'h7FFFFF, 23'h0);
    $display("reset test finished");
    repeat (2) @(posedge sys_clk);
    give_verdict();
  end
endmodule
